// ===== common/lux_event_pkg.sv
// Purpose: Shared constants, types and helpers of the light threshold event logic
// Assumes: 16-bit registers addressed by a 7-bit pointer
// Notes: Config word packs as cfg_t, msb first

package lux_event_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [6:0] OFS_RESULT = 7'h00;
    localparam logic [6:0] OFS_CONFIG = 7'h01;
    localparam logic [6:0] OFS_LOW = 7'h02;
    localparam logic [6:0] OFS_HIGH = 7'h03;
    localparam logic [6:0] OFS_MFR_ID = 7'h7e;
    localparam logic [6:0] OFS_DEV_ID = 7'h7f;

    localparam logic [15:0] RST_RESULT = 16'h0000;
    localparam logic [15:0] RST_LOW = 16'hc000;
    localparam logic [15:0] RST_HIGH = 16'hbfff;
    localparam logic [15:0] RST_CONFIG = 16'hc810;
    // Config bits software may change; the flags and overflow are hardware owned
    localparam logic [15:0] CFG_WR_MASK = 16'hfe1f;

    localparam logic [3:0] RANGE_AUTO = 4'hc;
    localparam int LIN_W = 27;

    typedef enum logic [1:0] {
        MODE_SHUTDOWN = 2'b00,
        MODE_SINGLE = 2'b01,
        MODE_CONT = 2'b10,
        MODE_CONT_ALT = 2'b11
    } mode_t;

    typedef struct packed {
        logic [3:0] range_select;
        logic conv_time;
        mode_t mode;
        logic overflow;
        logic conversion_done_flag;
        logic above_limit_flag;
        logic below_limit_flag;
        logic latch_sel;
        logic irq_polarity;
        logic exponent_mask_enable;
        logic [1:0] fault_count_select;
    } cfg_t;

    typedef struct packed {
        logic [3:0] exp;
        logic [11:0] mant;
    } lux_word_t;

    function automatic logic [LIN_W-1:0] to_linear(input lux_word_t w);
        to_linear = {15'h0000, w.mant} << w.exp;
    endfunction : to_linear

    function automatic logic [3:0] fault_need(input logic [1:0] fc);
        unique case (fc)
            2'b00: fault_need = 4'h1;
            2'b01: fault_need = 4'h2;
            2'b10: fault_need = 4'h4;
            2'b11: fault_need = 4'h8;
        endcase
    endfunction : fault_need

endpackage : lux_event_pkg

// ===== core/fault_run_counter.sv
// Purpose: Counts consecutive fault samples and reports when the run is long enough
// Assumes: sample is a one-cycle strobe per finished conversion
// Notes: Count saturates one below the needed length

`timescale 1ns/100ps
`default_nettype none

module fault_run_counter #(
    parameter int CNT_W = 4
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic sample,
    input wire logic fault,
    input wire logic [CNT_W-1:0] need,
    output logic qualified
);

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W:0] run;

    assign run = {1'b0, cnt_ff} + {{CNT_W{1'b0}}, 1'b1};
    assign qualified = sample && fault && (run >= {1'b0, need});

    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (sample)
        begin
            if (!fault)
                nxt_cnt = '0;
            else if (run < {1'b0, need})
                nxt_cnt = run[CNT_W-1:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end

    AST_RUN_BREAK:
    assert property (@(posedge sys_clk) disable iff (sys_rst)
        sample && !fault |=> cnt_ff == '0)
        else $error("fault run not restarted by a clean sample");

endmodule : fault_run_counter

`default_nettype wire

// ===== core/light_threshold_event_logic.sv
// Purpose: Limit comparison, flags and open-drain interrupt of an ambient light sensor
// Assumes: Register port and conversion engine run on sys_clk
// Notes: Read data appears the cycle after the read strobe

`timescale 1ns/100ps
`default_nettype none

module light_threshold_event_logic #(
    parameter logic [15:0] MFR_ID = 16'h1234, // Arbitrary value
    parameter logic [15:0] DEV_ID = 16'h0101  // Arbitrary value
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [6:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic conv_done,
    input wire lux_event_pkg::lux_word_t conv_result,
    input wire logic conv_overflow,
    output lux_event_pkg::mode_t conv_mode,
    output logic conv_time,
    output logic [3:0] range_select,
    output logic int_out,
    output logic int_oe_n
);
    import lux_event_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    cfg_t cfg_ff;
    cfg_t nxt_cfg;
    lux_word_t result_ff;
    lux_word_t nxt_result;
    lux_word_t low_ff;
    lux_word_t nxt_low;
    lux_word_t high_ff;
    lux_word_t nxt_high;
    logic irq_ff;
    logic nxt_irq;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic int_oe_n_ff;
    logic nxt_int_oe_n;

    logic cfg_rd;
    logic cfg_wr;
    logic above;
    logic below;
    logic hi_hit;
    logic lo_hit;
    logic [3:0] need;
    cfg_t wr_cfg;
    lux_word_t masked;

    assign cfg_rd = reg_rd && (reg_addr == OFS_CONFIG);
    assign cfg_wr = reg_wr && (reg_addr == OFS_CONFIG);
    assign wr_cfg = cfg_t'((reg_wdata & CFG_WR_MASK) | (cfg_ff & ~CFG_WR_MASK));

    // ----------------------------------------
    // Comparison on a common linear scale
    // ----------------------------------------
    // Exponents of result and limits may differ, so raw words cannot be compared
    assign above = to_linear(conv_result) > to_linear(high_ff);
    assign below = to_linear(conv_result) < to_linear(low_ff);
    assign need = fault_need(cfg_ff.fault_count_select);

    fault_run_counter #(
        .CNT_W(4)
    ) u_high_run (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .sample(conv_done),
        .fault(above),
        .need(need),
        .qualified(hi_hit)
    );

    fault_run_counter #(
        .CNT_W(4)
    ) u_low_run (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .sample(conv_done),
        .fault(below),
        .need(need),
        .qualified(lo_hit)
    );

    // ----------------------------------------
    // Result read view
    // ----------------------------------------
    always_comb
    begin
        masked = result_ff;
        if (cfg_ff.exponent_mask_enable && (cfg_ff.range_select < RANGE_AUTO))
            masked.exp = 4'h0;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        nxt_cfg = cfg_ff;
        nxt_result = result_ff;
        nxt_low = low_ff;
        nxt_high = high_ff;
        nxt_irq = irq_ff;
        nxt_rdata = rdata_ff;

        if (cfg_wr)
            nxt_cfg = wr_cfg;
        else if (conv_done && (cfg_ff.mode == MODE_SINGLE))
            nxt_cfg.mode = MODE_SHUTDOWN;
        if (reg_wr && (reg_addr == OFS_LOW))
            nxt_low = lux_word_t'(reg_wdata);
        if (reg_wr && (reg_addr == OFS_HIGH))
            nxt_high = lux_word_t'(reg_wdata);

        if (conv_done)
        begin
            nxt_result = conv_result;
            nxt_cfg.overflow = conv_overflow;
        end

        // Shutdown writes do not clear; a finishing conversion wins over any clear
        if (cfg_rd || (cfg_wr && (mode_t'(reg_wdata[10:9]) != MODE_SHUTDOWN)))
            nxt_cfg.conversion_done_flag = 1'b0;
        if (conv_done)
            nxt_cfg.conversion_done_flag = 1'b1;

        // Flags only move on a conversion or a read, so shutdown keeps them
        if (cfg_ff.latch_sel)
        begin
            if (cfg_rd)
            begin
                nxt_cfg.above_limit_flag = 1'b0;
                nxt_cfg.below_limit_flag = 1'b0;
                nxt_irq = 1'b0;
            end
            if (hi_hit)
            begin
                nxt_cfg.above_limit_flag = 1'b1;
                nxt_irq = 1'b1;
            end
            if (lo_hit)
            begin
                nxt_cfg.below_limit_flag = 1'b1;
                nxt_irq = 1'b1;
            end
        end
        else if (conv_done)
        begin
            if (hi_hit)
                nxt_cfg.above_limit_flag = 1'b1;
            else if (!above)
                nxt_cfg.above_limit_flag = 1'b0;
            if (lo_hit)
                nxt_cfg.below_limit_flag = 1'b1;
            else if (!below)
                nxt_cfg.below_limit_flag = 1'b0;
            // Hysteresis: asserted above high, released only below low
            if (hi_hit)
                nxt_irq = 1'b1;
            else if (lo_hit)
                nxt_irq = 1'b0;
        end

        if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_RESULT: nxt_rdata = masked;
                OFS_CONFIG: nxt_rdata = cfg_ff;
                OFS_LOW: nxt_rdata = low_ff;
                OFS_HIGH: nxt_rdata = high_ff;
                OFS_MFR_ID: nxt_rdata = MFR_ID;
                OFS_DEV_ID: nxt_rdata = DEV_ID;
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end

    // Open drain: driven low when event state and polarity differ
    assign nxt_int_oe_n = ~(irq_ff ^ cfg_ff.irq_polarity);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cfg_ff <= cfg_t'(RST_CONFIG);
            result_ff <= lux_word_t'(RST_RESULT);
            low_ff <= lux_word_t'(RST_LOW);
            high_ff <= lux_word_t'(RST_HIGH);
            irq_ff <= 1'b0;
            rdata_ff <= 16'h0000;
            int_oe_n_ff <= 1'b1;
        end
        else
        begin
            cfg_ff <= nxt_cfg;
            result_ff <= nxt_result;
            low_ff <= nxt_low;
            high_ff <= nxt_high;
            irq_ff <= nxt_irq;
            rdata_ff <= nxt_rdata;
            int_oe_n_ff <= nxt_int_oe_n;
        end
    end

    assign reg_rdata = rdata_ff;
    assign conv_mode = cfg_ff.mode;
    assign conv_time = cfg_ff.conv_time;
    assign range_select = cfg_ff.range_select;
    assign int_out = 1'b0;
    assign int_oe_n = int_oe_n_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_cfg_read;
        reg_rd && (reg_addr == OFS_CONFIG) && !conv_done;
    endsequence

    sequence s_shutdown_write;
        reg_wr && (reg_addr == OFS_CONFIG) && (reg_wdata[10:9] == 2'b00) && !conv_done
            && !reg_rd;
    endsequence

    AST_DONE_SETS:
    assert property (conv_done |=> cfg_ff.conversion_done_flag)
        else $error("done flag not set by conversion");

    AST_READ_CLEARS_DONE:
    assert property (s_cfg_read |=> !cfg_ff.conversion_done_flag)
        else $error("done flag survived a config read");

    AST_SHUTDOWN_KEEPS_DONE:
    assert property (s_shutdown_write |=> $stable(cfg_ff.conversion_done_flag))
        else $error("shutdown write changed done flag");

    AST_PIN_LEVEL:
    assert property (##1 int_oe_n == !($past(irq_ff) ^ $past(cfg_ff.irq_polarity)))
        else $error("interrupt pin drive disagrees with polarity");

    AST_MASK_EXP:
    assert property (reg_rd && (reg_addr == OFS_RESULT) && cfg_ff.exponent_mask_enable
        && (cfg_ff.range_select < RANGE_AUTO) |=> reg_rdata[15:12] == 4'h0)
        else $error("result exponent not masked");

    AST_LATCH_HOLD:
    assert property (cfg_ff.latch_sel && irq_ff && !cfg_rd |=> irq_ff)
        else $error("latched interrupt dropped without a read");

    AST_HIGH_ONE:
    assert property (conv_done && above && (cfg_ff.fault_count_select == 2'b00)
        |=> cfg_ff.above_limit_flag && irq_ff)
        else $error("single fault above high did not report");

    AST_LOW_ONE:
    assert property (conv_done && below && (cfg_ff.fault_count_select == 2'b00)
        |=> cfg_ff.below_limit_flag)
        else $error("single fault below low did not report");

    AST_TRANSPARENT:
    assert property (!cfg_ff.latch_sel && conv_done && !above |=> !cfg_ff.above_limit_flag)
        else $error("transparent high flag did not follow result");

    AST_SINGLE_ENDS:
    assert property (conv_done && (cfg_ff.mode == MODE_SINGLE) && !cfg_wr
        |=> cfg_ff.mode == MODE_SHUTDOWN)
        else $error("single conversion did not return to shutdown");

    // The limit flags must survive any config write without a conversion or read
    AST_WRITE_KEEPS_FLAGS:
    assert property (cfg_wr && !conv_done && !reg_rd
        |=> $stable(cfg_ff.above_limit_flag) && $stable(cfg_ff.below_limit_flag))
        else $error("config write changed a limit flag");

    AST_SHUTDOWN_KEEPS_IRQ:
    assert property (s_shutdown_write |=> $stable(irq_ff))
        else $error("shutdown write changed interrupt state");

    AST_LATCH_READ_CLEARS:
    assert property (cfg_ff.latch_sel && cfg_rd && !conv_done
        |=> !irq_ff && !cfg_ff.above_limit_flag && !cfg_ff.below_limit_flag)
        else $error("latched report survived a config read");

    AST_POL_ONE_RELEASE:
    assert property (irq_ff && cfg_ff.irq_polarity |=> int_oe_n)
        else $error("inverted polarity event did not release the pin");

endmodule : light_threshold_event_logic

`default_nettype wire

// ===== tb/host_pin_model.sv
// Purpose: Host side view of the open-drain interrupt line
// Assumes: An external pull-up holds the line high whenever it is released
// Notes: The host only ever sees the resolved line level

`timescale 1ns/100ps
`default_nettype none

module host_pin_model (
    input wire logic int_out,
    input wire logic int_oe_n,
    output logic pin_level
);
    // Released line floats up; a driven line shows the driven value
    assign pin_level = int_oe_n ? 1'b1 : int_out;
endmodule : host_pin_model

`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench of the light threshold event logic
// Assumes: Register strobes and conversion strobes are one-cycle pulses
// Notes: Pin level is checked through the pull-up model

`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import lux_event_pkg::*;
    typedef struct packed {logic [6:0] addr; logic [15:0] value;} row_t;
    localparam row_t ROWS [7] = '{'{OFS_RESULT, RST_RESULT}, '{OFS_CONFIG, RST_CONFIG},
        '{OFS_LOW, RST_LOW}, '{OFS_HIGH, RST_HIGH}, '{OFS_MFR_ID, 16'h1234},
        '{OFS_DEV_ID, 16'h0101}, '{7'h40, 16'h0000}};
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic conv_done = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [15:0] reg_wdata = 16'h0000;
    lux_word_t conv_result = 16'h0000;
    logic [15:0] reg_rdata;
    mode_t conv_mode;
    logic conv_time, int_out, int_oe_n, pin_level;
    logic [3:0] range_select;
    int failures = 0;
    int total_checks = 0;

    light_threshold_event_logic light_threshold_event_logic_i (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done),
        .conv_result(conv_result), .conv_overflow(1'b0), .conv_mode(conv_mode),
        .conv_time(conv_time), .range_select(range_select), .int_out(int_out),
        .int_oe_n(int_oe_n));
    host_pin_model host_pin_model_i (.int_out(int_out), .int_oe_n(int_oe_n),
        .pin_level(pin_level));

    initial
    begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic wr(input logic [6:0] addr, input logic [15:0] data);
        @(negedge sys_clk);
        reg_addr = addr;
        reg_wdata = data;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr

    // Read data holds until the next read, so one spare cycle is safe
    task automatic rd_chk(input logic [6:0] addr, input logic [15:0] exp);
        @(negedge sys_clk);
        reg_addr = addr;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        @(negedge sys_clk);
        check("reg_rdata", exp, reg_rdata);
    endtask : rd_chk

    task automatic conv(input logic [15:0] value);
        @(negedge sys_clk);
        conv_result = value;
        conv_done = 1'b1;
        @(negedge sys_clk);
        conv_done = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask : conv

    task automatic pin_chk(input logic exp);
        repeat (2) @(negedge sys_clk);
        check("pin_level", {15'h0000, exp}, {15'h0000, pin_level});
    endtask : pin_chk

    task automatic complete_run;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(negedge sys_clk);
        sys_rst = 1'b0;
        foreach (ROWS[i])
            rd_chk(ROWS[i].addr, ROWS[i].value);
        pin_chk(1'b1);
        // Done flag: set, read-cleared, kept across a shutdown write
        conv(16'h0080);
        rd_chk(OFS_CONFIG, 16'hc890);
        rd_chk(OFS_CONFIG, 16'hc810);
        conv(16'h0080);
        wr(OFS_CONFIG, 16'hc810);
        rd_chk(OFS_CONFIG, 16'hc890);
        conv(16'h0080);
        wr(OFS_CONFIG, 16'hca10);
        check("conv_mode", 16'(MODE_SINGLE), {14'h0000, conv_mode});
        rd_chk(OFS_CONFIG, 16'hca10);
        conv(16'h0080);
        check("conv_mode", 16'(MODE_SHUTDOWN), {14'h0000, conv_mode});
        rd_chk(OFS_CONFIG, 16'hc890);
        // Limits with differing exponents: 16 and 256 against 128, 512 and 8
        wr(OFS_HIGH, 16'h0100);
        wr(OFS_LOW, 16'h0010);
        for (int fc = 0; fc < 4; fc++)
        begin
            wr(OFS_CONFIG, 16'hcc10 | 16'(fc));
            conv(16'h0080);
            repeat ((1 << fc) - 1) conv(16'h1100);
            pin_chk(1'b1);
            conv(16'h1100);
            pin_chk(1'b0);
            rd_chk(OFS_CONFIG, 16'hccd0 | 16'(fc));
            pin_chk(1'b1);
        end
        wr(OFS_CONFIG, 16'hcc10);
        conv(16'h0008);
        pin_chk(1'b0);
        rd_chk(OFS_CONFIG, 16'hccb0);
        // Inverted polarity: idle drives low, event releases
        wr(OFS_CONFIG, 16'hcc18);
        pin_chk(1'b0);
        conv(16'h1100);
        pin_chk(1'b1);
        rd_chk(OFS_CONFIG, 16'hccd8);
        pin_chk(1'b0);
        // Manual range with masking; comparison still sees 512 above 256
        wr(OFS_CONFIG, 16'h0414);
        check("range_select", 16'h0000, {12'h000, range_select});
        check("conv_time", 16'h0000, {15'h0000, conv_time});
        conv(16'h1100);
        rd_chk(OFS_RESULT, 16'h0100);
        pin_chk(1'b0);
        wr(OFS_CONFIG, 16'h0014);
        pin_chk(1'b0);
        rd_chk(OFS_CONFIG, 16'h00d4);
        wr(OFS_CONFIG, 16'hc414);
        rd_chk(OFS_RESULT, 16'h1100);
        // Transparent mode: flags follow samples, pin has hysteresis
        wr(OFS_CONFIG, 16'hcc00);
        conv(16'h1100);
        pin_chk(1'b0);
        rd_chk(OFS_CONFIG, 16'hccc0);
        pin_chk(1'b0);
        conv(16'h0080);
        rd_chk(OFS_CONFIG, 16'hcc80);
        pin_chk(1'b0);
        conv(16'h0008);
        pin_chk(1'b1);
        rd_chk(OFS_CONFIG, 16'hcca0);
        // Flag bits ignore writes; result register ignores writes
        wr(OFS_CONFIG, 16'hcde0);
        rd_chk(OFS_CONFIG, 16'hcc20);
        wr(OFS_RESULT, 16'hffff);
        rd_chk(OFS_RESULT, 16'h0008);
        // Mid-run reset with an event pending: pin released, config back to reset word
        conv(16'h1100);
        pin_chk(1'b0);
        @(negedge sys_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        check("conv_time", {15'h0000, RST_CONFIG[11]}, {15'h0000, conv_time});
        check("range_select", {12'h000, RST_CONFIG[15:12]}, {12'h000, range_select});
        check("conv_mode", 16'(MODE_SHUTDOWN), {14'h0000, conv_mode});
        check("int_out", 16'h0000, {15'h0000, int_out});
        pin_chk(1'b1);
        rd_chk(OFS_CONFIG, RST_CONFIG);
        rd_chk(OFS_HIGH, RST_HIGH);
        complete_run();
    end
endmodule : tb_top

`default_nettype wire
